// File: core/mssc_channel.sv
`timescale 1ns/1ps
`include "mssc_consts.svh"
module mssc_channel
  import mssc_pkg::*;
(
  // Clock and reset
  input  wire logic           core_clk_i,
  input  wire logic           rst_b_i,
  // Register port
  input  wire mssc_reg_req_t  reg_req_i,
  output logic [7:0]          reg_rdata_o,
  // Oscillator mode and timer tick
  input  wire logic           osc_mode_i,
  input  wire logic           timer_tick_i,
  // Serial pins
  input  wire logic           serial_clock_pin_i,
  output logic                serial_clock_pin_o,
  output logic                serial_clock_oe_b_o,
  input  wire logic           serial_in_pin_i,
  output logic                serial_out_pin_o,
  input  wire logic           bus_line_a_i,
  input  wire logic           bus_line_b_i,
  output mssc_bus_pins_t      bus_pins_o,
  // Events
  output logic                transfer_interrupt_o,
  output logic [1:0]          word_class_o
);

  logic [1:0] sck_sync, next_sck_sync;
  logic [1:0] si_sync, next_si_sync;
  logic [1:0] sa_sync, next_sa_sync;
  logic [1:0] sb_sync, next_sb_sync;
  logic [7:0] serial_shift_register, next_serial_shift_register;
  logic [7:0] slave_address_register, next_slave_address_register;
  logic [7:0] serial_clock_select, next_serial_clock_select;
  logic [7:0] channel_mode_register, next_channel_mode_register;
  logic [7:0] bus_control_register, next_bus_control_register;
  logic [7:0] interrupt_timing_register, next_interrupt_timing_register;
  logic [1:0] out_latch, next_out_latch;
  logic [3:0] bit_count, next_bit_count;
  logic [8:0] prescale, next_prescale;
  logic       div_tick_q, next_div_tick_q;
  logic       sck_out, next_sck_out;
  logic       sck_prev, next_sck_prev;
  logic       irq, next_irq;
  logic [1:0] word_class, next_word_class;
  logic       after_release, next_after_release;
  logic [7:0] rdata, next_rdata;
  mssc_state_t state, next_state;

  mssc_mode_t mode;
  logic       enable;
  logic       lsb_first;
  logic       internal_clk;
  logic       int_tick;
  logic       ext_fall;
  logic       ext_rise;
  logic       shift_fall;
  logic       shift_rise;
  logic       in_bit;
  logic       tx_bit;
  logic       match;
  logic       shift_wr;
  logic [3:0] sel;
  logic [8:0] base_div;

  assign enable    = channel_mode_register[`MSSC_BIT_ENABLE];
  assign lsb_first = channel_mode_register[`MSSC_BIT_MODE_LO] &
                     ~channel_mode_register[`MSSC_BIT_MODE_HI];
  assign internal_clk = channel_mode_register[`MSSC_BIT_CSRC_HI];
  assign shift_wr  = reg_req_i.wr && (reg_req_i.addr == `MSSC_REG_SHIFT);
  assign sel       = serial_clock_select[3:0];

  always_comb begin
    mode = MSSC_THREE_WIRE;
    if (channel_mode_register[`MSSC_BIT_MODE_HI]) begin
      mode = channel_mode_register[`MSSC_BIT_MODE_MID] ? MSSC_TWO_WIRE : MSSC_ADDR_BUS;
    end
  end

  // Divider: base clock is fx/2 or fx, selection picks a power of two
  always_comb begin
    base_div = 9'h000;
    if (sel >= 4'h6 && sel <= 4'hD) begin
      base_div = 9'(9'h004 << (sel - 4'h6));
    end
    if (!osc_mode_i) begin
      base_div = 9'(base_div << 1);
    end
  end

  // Pin domain crossing: two flops before any use
  always_comb begin
    next_sck_sync = {sck_sync[0], serial_clock_pin_i};
    next_si_sync  = {si_sync[0], serial_in_pin_i};
    next_sa_sync  = {sa_sync[0], bus_line_a_i};
    next_sb_sync  = {sb_sync[0], bus_line_b_i};
  end

  always_comb begin
    next_prescale = 9'(prescale + 9'h001);
    next_div_tick_q = 1'b0;
    if (base_div != 9'h000 && next_prescale >= (base_div >> 1)) begin
      next_prescale = 9'h000;
      next_div_tick_q = 1'b1;
    end
    if (state == MSSC_IDLE) begin
      next_prescale = 9'h000;
    end
  end

  always_comb begin
    int_tick = 1'b0;
    if (internal_clk) begin
      int_tick = channel_mode_register[`MSSC_BIT_CSRC_LO] ? div_tick_q : timer_tick_i;
    end
  end

  assign ext_fall = ~internal_clk & sck_prev & ~sck_sync[1];
  assign ext_rise = ~internal_clk & ~sck_prev & sck_sync[1];
  assign shift_fall = ext_fall | (internal_clk & int_tick & (state == MSSC_HIGH));
  assign shift_rise = ext_rise | (internal_clk & int_tick & (state == MSSC_LOW));

  always_comb begin
    in_bit = si_sync[1];
    if (mode != MSSC_THREE_WIRE) begin
      in_bit = channel_mode_register[`MSSC_BIT_MODE_LO] ? sa_sync[1] : sb_sync[1];
    end
  end

  assign tx_bit = lsb_first ? serial_shift_register[0] : serial_shift_register[7];

  always_comb begin
    match = (serial_shift_register[7:1] == slave_address_register[7:1]) &&
            (interrupt_timing_register[`MSSC_BIT_MASK] ||
             serial_shift_register[0] == slave_address_register[0]);
    if (mode != MSSC_ADDR_BUS) begin
      match = 1'b0;
    end
  end

  // Transfer engine and registers
  always_comb begin
    next_state = state;
    next_bit_count = bit_count;
    next_sck_out = sck_out;
    next_sck_prev = sck_sync[1];
    next_irq = 1'b0;
    next_word_class = word_class;
    next_after_release = after_release;
    next_out_latch = out_latch;
    next_serial_shift_register = serial_shift_register;
    next_slave_address_register = slave_address_register;
    next_serial_clock_select = serial_clock_select;
    next_channel_mode_register = channel_mode_register;
    next_bus_control_register = bus_control_register;
    next_interrupt_timing_register = interrupt_timing_register;
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `MSSC_REG_SHIFT: begin
          next_serial_shift_register = reg_req_i.data;
          if (mode == MSSC_ADDR_BUS) begin
            next_bus_control_register[`MSSC_BIT_BUSY] = 1'b0;
          end
        end
        `MSSC_REG_SLAVE:  next_slave_address_register = reg_req_i.data;
        `MSSC_REG_CLKSEL: next_serial_clock_select = {4'h8, reg_req_i.data[3:0]};
        `MSSC_REG_MODE: begin
          next_channel_mode_register = reg_req_i.data;
          next_channel_mode_register[`MSSC_BIT_MATCH] = channel_mode_register[`MSSC_BIT_MATCH];
        end
        `MSSC_REG_BUSCTL: next_bus_control_register = reg_req_i.data;
        `MSSC_REG_INTTIM: next_interrupt_timing_register = reg_req_i.data;
        `MSSC_REG_LATCH: begin
          next_out_latch = reg_req_i.data[1:0];
          if (mode != MSSC_THREE_WIRE && !internal_clk) begin
            next_sck_out = reg_req_i.data[2];
          end
        end
        default: begin
        end
      endcase
    end
    if (enable && shift_wr) begin
      next_state = MSSC_HIGH;
      next_bit_count = 4'h0;
      next_sck_out = 1'b1;
    end else begin
      unique case (state)
        MSSC_IDLE: begin
        end
        MSSC_HIGH: begin
          if (shift_fall) begin
            next_state = MSSC_LOW;
            next_sck_out = 1'b0;
            next_out_latch = {tx_bit, tx_bit};
          end
        end
        MSSC_LOW: begin
          if (shift_rise) begin
            next_sck_out = 1'b1;
            next_bit_count = 4'(bit_count + 4'h1);
            next_serial_shift_register = lsb_first ?
              {in_bit, serial_shift_register[7:1]} :
              {serial_shift_register[6:0], in_bit};
            next_state = MSSC_HIGH;
            if (4'(bit_count + 4'h1) == `MSSC_BITS_PER_WORD) begin
              next_state = MSSC_IDLE;
              next_irq = 1'b1;
              if (mode == MSSC_ADDR_BUS) begin
                next_out_latch = 2'b11;
              end
            end
          end
        end
        default: next_state = MSSC_IDLE;
      endcase
    end
    // Classification on each finished word in addressed mode
    if (mode == MSSC_ADDR_BUS && state == MSSC_IDLE && irq) begin
      if (after_release) begin
        next_word_class = 2'h1;
        next_after_release = 1'b0;
        next_channel_mode_register[`MSSC_BIT_MATCH] = match;
        if (!match) begin
          next_bus_control_register[`MSSC_BIT_RELEASE] = 1'b0;
        end
      end else begin
        next_word_class = bus_control_register[`MSSC_BIT_CMD] ? 2'h2 : 2'h3;
      end
      if (bus_control_register[`MSSC_BIT_BUSY_EN]) begin
        next_bus_control_register[`MSSC_BIT_BUSY] = 1'b1;
      end
    end
    if (mode == MSSC_ADDR_BUS && reg_req_i.wr && reg_req_i.addr == `MSSC_REG_BUSCTL &&
        reg_req_i.data[`MSSC_BIT_RELEASE]) begin
      next_after_release = 1'b1;
    end
    if (mode != MSSC_ADDR_BUS) begin
      next_bus_control_register[`MSSC_BIT_BUSY] = 1'b0;
      next_word_class = 2'h0;
    end
    if (!next_channel_mode_register[`MSSC_BIT_ENABLE]) begin
      next_channel_mode_register[`MSSC_BIT_MATCH] = 1'b0;
      next_state = MSSC_IDLE;
    end
  end

  // Interrupt gating: wake-up passes matching address words only, or bus release writes when the source bit is set
  logic fire;
  always_comb begin
    fire = irq;
    if (mode == MSSC_ADDR_BUS && channel_mode_register[`MSSC_BIT_WAKE]) begin
      fire = irq && after_release && match;
      if (interrupt_timing_register[`MSSC_BIT_SRC]) begin
        fire = reg_req_i.wr && (reg_req_i.addr == `MSSC_REG_BUSCTL) &&
               reg_req_i.data[`MSSC_BIT_RELEASE];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_req_i.addr)
      `MSSC_REG_SHIFT:  next_rdata = serial_shift_register;
      `MSSC_REG_SLAVE:  next_rdata = slave_address_register;
      `MSSC_REG_CLKSEL: next_rdata = serial_clock_select;
      `MSSC_REG_MODE:   next_rdata = channel_mode_register;
      `MSSC_REG_BUSCTL: next_rdata = bus_control_register;
      `MSSC_REG_INTTIM: next_rdata = interrupt_timing_register;
      `MSSC_REG_LATCH:  next_rdata = {5'h00, sck_out, out_latch};
      default:          next_rdata = 8'h00;
    endcase
  end

  // Shift and slave address have no reset value; zero is only a tidy start
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_sync <= 2'h3;
      si_sync <= 2'h0;
      sa_sync <= 2'h3;
      sb_sync <= 2'h3;
      serial_shift_register <= 8'h00;
      slave_address_register <= 8'h00;
      serial_clock_select <= `MSSC_CLKSEL_RESET;
      channel_mode_register <= `MSSC_MODE_RESET;
      bus_control_register <= `MSSC_BUSCTL_RESET;
      interrupt_timing_register <= `MSSC_INTTIM_RESET;
      out_latch <= 2'h3;
      bit_count <= 4'h0;
      prescale <= 9'h000;
      div_tick_q <= 1'b0;
      sck_out <= 1'b1;
      sck_prev <= 1'b1;
      irq <= 1'b0;
      word_class <= 2'h0;
      after_release <= 1'b0;
      rdata <= 8'h00;
      transfer_interrupt_o <= 1'b0;
      state <= MSSC_IDLE;
    end else begin
      sck_sync <= next_sck_sync;
      si_sync <= next_si_sync;
      sa_sync <= next_sa_sync;
      sb_sync <= next_sb_sync;
      serial_shift_register <= next_serial_shift_register;
      slave_address_register <= next_slave_address_register;
      serial_clock_select <= next_serial_clock_select;
      channel_mode_register <= next_channel_mode_register;
      bus_control_register <= next_bus_control_register;
      interrupt_timing_register <= next_interrupt_timing_register;
      out_latch <= next_out_latch;
      bit_count <= next_bit_count;
      prescale <= next_prescale;
      div_tick_q <= next_div_tick_q;
      sck_out <= next_sck_out;
      sck_prev <= next_sck_prev;
      irq <= next_irq;
      word_class <= next_word_class;
      after_release <= next_after_release;
      rdata <= next_rdata;
      transfer_interrupt_o <= fire;
      state <= next_state;
    end
  end

  // Data pins straight from flops, enables decoded from mode bits and the output latch; open-drain lines drive only a low
  assign reg_rdata_o = rdata;
  assign word_class_o = word_class;
  assign serial_clock_pin_o = sck_out;
  assign serial_clock_oe_b_o = ~(internal_clk | (mode == MSSC_TWO_WIRE));
  assign serial_out_pin_o = out_latch[1];
  assign bus_pins_o = '{a_out: 1'b0, b_out: 1'b0,
                        a_oe_b: out_latch[0] | (mode == MSSC_THREE_WIRE) |
                                ~channel_mode_register[`MSSC_BIT_MODE_LO],
                        b_oe_b: out_latch[1] | (mode == MSSC_THREE_WIRE) |
                                channel_mode_register[`MSSC_BIT_MODE_LO]};

endmodule // mssc_channel

// File: include/mssc_consts.svh
`ifndef MSSC_CONSTS_SVH
`define MSSC_CONSTS_SVH
`define MSSC_REG_SHIFT     3'h0
`define MSSC_REG_SLAVE     3'h1
`define MSSC_REG_CLKSEL    3'h2
`define MSSC_REG_MODE      3'h3
`define MSSC_REG_BUSCTL    3'h4
`define MSSC_REG_INTTIM    3'h5
`define MSSC_REG_LATCH     3'h6
`define MSSC_CLKSEL_RESET  8'h88
`define MSSC_MODE_RESET    8'h00
`define MSSC_BUSCTL_RESET  8'h00
`define MSSC_INTTIM_RESET  8'h00
`define MSSC_BIT_ENABLE    7
`define MSSC_BIT_MATCH     6
`define MSSC_BIT_WAKE      5
`define MSSC_BIT_MODE_HI   4
`define MSSC_BIT_MODE_MID  3
`define MSSC_BIT_MODE_LO   2
`define MSSC_BIT_CSRC_HI   1
`define MSSC_BIT_CSRC_LO   0
`define MSSC_BIT_BUSY_EN   7
`define MSSC_BIT_BUSY      6
`define MSSC_BIT_CMD       3
`define MSSC_BIT_RELEASE   2
`define MSSC_BIT_ACK       0
`define MSSC_BIT_SRC       5
`define MSSC_BIT_MASK      4
`define MSSC_BITS_PER_WORD 4'h8
`define MSSC_LINE_RELEASE  8'hFF
`endif

// File: include/mssc_pkg.sv
package mssc_pkg;
  typedef enum logic [1:0] {MSSC_THREE_WIRE, MSSC_ADDR_BUS, MSSC_TWO_WIRE} mssc_mode_t;
  typedef enum logic [1:0] {MSSC_IDLE, MSSC_LOW, MSSC_HIGH} mssc_state_t;
  typedef struct packed {
    logic       wr;
    logic [2:0] addr;
    logic [7:0] data;
  } mssc_reg_req_t;
  typedef struct packed {
    logic a_out;
    logic a_oe_b;
    logic b_out;
    logic b_oe_b;
  } mssc_bus_pins_t;
endpackage

// File: tb/mssc_checker.sv
`timescale 1ns/1ps
module mssc_checker
  import mssc_pkg::*;
(
  // Clock and reset
  input  wire logic           core_clk_i,
  input  wire logic           rst_b_i,
  // Register port
  input  wire mssc_reg_req_t  reg_req_i,
  input  wire logic [7:0]     reg_rdata_o,
  // Serial side
  input  wire logic           serial_clock_pin_o,
  input  wire logic           serial_clock_oe_b_o,
  input  wire mssc_bus_pins_t bus_pins_o,
  input  wire logic           transfer_interrupt_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       sck_d;
  logic       rise;
  logic       sh_wr;

  assign sh_wr = reg_req_i.wr && reg_req_i.addr == 3'h0;
  assign rise  = serial_clock_pin_o && !sck_d;

  // Shadow of the mode register, since the checker cannot see inside
  always_comb begin
    next_mode = (reg_req_i.wr && reg_req_i.addr == 3'h3) ? reg_req_i.data : mode;
    next_cnt  = sh_wr ? 4'h0 : cnt + {3'h0, rise};
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode  <= 8'h00;
      cnt   <= 4'h0;
      sck_d <= 1'b1;
    end else begin
      mode  <= next_mode;
      cnt   <= next_cnt;
      sck_d <= serial_clock_pin_o;
    end
  end

  sequence eighth_rise;
    rise && cnt == 4'h7;
  endsequence

  sequence word_done;
    cnt == 4'h8 && !sh_wr;
  endsequence

  clksel_nibble_a: assert property (reg_req_i.addr == 3'h2 |=> reg_rdata_o[7:4] == 4'h8)
    else $error("clock select upper nibble not 8");
  match_off_a: assert property (
    !reg_req_i.wr && reg_req_i.addr == 3'h3 && !mode[7] |=> !reg_rdata_o[6])
    else $error("match flag set while channel disabled");
  irq_pulse_a: assert property (transfer_interrupt_o |=> !transfer_interrupt_o)
    else $error("transfer interrupt longer than one cycle");
  irq_count_a: assert property (
    transfer_interrupt_o |-> cnt == 4'h8 || (rise && cnt == 4'h7))
    else $error("interrupt without eight shift clocks");
  eighth_irq_a: assert property (eighth_rise |-> ##[0:4] transfer_interrupt_o)
    else $error("no interrupt after eighth shift clock");
  cnt_max_a: assert property (cnt <= 4'h8)
    else $error("more than eight shift clocks in one word");
  idle_hold_a: assert property (word_done |-> serial_clock_pin_o)
    else $error("serial clock left idle level after word");
  start_a: assert property (
    sh_wr && mode[7] && mode[1:0] == 2'b11 |-> ##[1:100] !serial_clock_pin_o)
    else $error("enabled shift write did not start clock");
  dis_quiet_a: assert property (sh_wr && !mode[7] |=> serial_clock_pin_o [*8])
    else $error("disabled shift write toggled clock");
  drive_clk_a: assert property (mode[1:0] == 2'b11 && $stable(mode) |-> !serial_clock_oe_b_o)
    else $error("internal clock not driven on pin");
  bus_rel_a: assert property (
    !mode[4] && $stable(mode) |-> bus_pins_o.a_oe_b && bus_pins_o.b_oe_b)
    else $error("bus lines pulled in three-wire mode");
endmodule // mssc_checker

bind mssc_channel mssc_checker u_checker (.core_clk_i, .rst_b_i, .reg_req_i, .reg_rdata_o,
  .serial_clock_pin_o, .serial_clock_oe_b_o, .bus_pins_o, .transfer_interrupt_o);

// File: tb/mssc_peer.sv
`timescale 1ns/1ps
module mssc_peer (
  // Serial side
  input  wire logic       sck_i,
  input  wire logic       so_i,
  output logic            si_o,
  // Bench side
  input  wire logic       load_i,
  input  wire logic [7:0] tx_i,
  output logic [7:0]      rx_o
);
  logic [3:0] k;
  initial si_o = 1'b0;
  // Between words the line flips, so a stale bit is never read as good data
  always @(negedge sck_i or posedge load_i) begin
    if (load_i) begin
      k    <= 4'h0;
      si_o <= ~si_o;
    end else begin
      si_o <= tx_i[3'h7 - k[2:0]];
      k    <= k + 4'h1;
    end
  end
  always @(posedge sck_i) begin
    rx_o <= {rx_o[6:0], so_i};
  end
endmodule // mssc_peer

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module testbench
  import mssc_pkg::*;
;
  logic          core_clk_i = 1'b0;
  logic          rst_b_i    = 1'b0;
  mssc_reg_req_t req        = '0;
  logic [7:0]    rdata;
  logic          osc        = 1'b0;
  logic          load       = 1'b0;
  logic [7:0]    ptx        = 8'h00;
  logic [7:0]    prx;
  logic          sck;
  logic          si;
  logic          so;
  logic          irq;
  mssc_bus_pins_t bpins;
  logic [1:0]    wclass;
  int            n_errors   = 0;
  int            checked    = 0;
  integer        seed       = 1;

  always #25 core_clk_i = ~core_clk_i;

  mssc_channel DUT (.core_clk_i, .rst_b_i, .reg_req_i(req), .reg_rdata_o(rdata),
    .osc_mode_i(osc), .timer_tick_i(1'b0), .serial_clock_pin_i(1'b1),
    .serial_clock_pin_o(sck), .serial_clock_oe_b_o(), .serial_in_pin_i(si),
    .serial_out_pin_o(so), .bus_line_a_i(1'b1), .bus_line_b_i(si & bpins.b_oe_b),
    .bus_pins_o(bpins), .transfer_interrupt_o(irq), .word_class_o(wclass));
  mssc_peer u_peer (.sck_i(sck), .so_i(so), .si_o(si), .load_i(load), .tx_i(ptx), .rx_o(prx));

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i) req <= '{1'b1, a, d};
    @(posedge core_clk_i) req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_i) req <= '{1'b0, a, 8'h00};
    @(posedge core_clk_i);
    @(negedge core_clk_i) d = rdata;
  endtask

  task automatic xfer(input logic [2:0] m, input logic [7:0] dtx, input logic [7:0] pv);
    logic [7:0] got;
    logic [31:0] r;
    int n;
    logic lsb;
    lsb = (m == 3'b001);
    r = $random(seed);
    @(posedge core_clk_i) begin
      ptx  <= pv;
      load <= 1'b1;
      osc  <= r[0];
    end
    @(posedge core_clk_i) load <= 1'b0;
    // Mode is only changed with the channel stopped
    wr(3'h3, {3'h0, m, 2'h3});
    rd(3'h3, got);
    `CHK(got, {3'h0, m, 2'h3}, "mode readback while stopped")
    wr(3'h3, {3'h4, m, 2'h3});
    wr(3'h0, dtx);
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(negedge core_clk_i);
      n++;
    end
    `CHK(irq, 1'b1, "no transfer interrupt")
    rd(3'h0, got);
    `CHK(got, lsb ? rev8(pv) : pv, "received word")
    `CHK(prx, lsb ? rev8(dtx) : dtx, "word seen by peer")
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] v;
    logic [31:0] r;
    int n;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(3'h2, v);
    `CHK(v, 8'h88, "clock select reset")
    rd(3'h3, v);
    `CHK(v, 8'h00, "mode reset")
    wr(3'h2, 8'h08);
    rd(3'h2, v);
    `CHK(v, 8'h88, "clock select readback")
    r = $random(seed);
    wr(3'h1, r[7:0]);
    rd(3'h1, v);
    `CHK(v, r[7:0], "slave address readback")
    // A shift write with the channel stopped only stores the byte
    wr(3'h3, 8'h03);
    wr(3'h0, 8'hA5);
    n = 0;
    repeat (200) begin
      @(negedge core_clk_i);
      if (irq === 1'b1) n++;
    end
    `CHK(n, 0, "interrupt while stopped")
    rd(3'h0, v);
    `CHK(v, 8'hA5, "stored byte while stopped")
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      xfer({2'b00, r[16] ^ (i == 1)}, (i < 2) ? 8'h01 : r[7:0], (i < 2) ? 8'h80 : r[15:8]);
    end
    // Addressed bus: stop, switch mode, then flag a bus release
    wr(3'h3, 8'h03);
    wr(3'h3, 8'h13);
    wr(3'h4, 8'h04);
    r = $random(seed);
    wr(3'h1, r[7:0]);
    xfer(3'b100, 8'hFF, r[7:0]);
    `CHK(wclass, 2'h1, "address word class")
    `CHK(bpins.b_oe_b, 1'b1, "line released after word")
    rd(3'h3, v);
    `CHK(v[6], 1'b1, "address match flag")
    xfer(3'b100, 8'hFF, r[15:8]);
    `CHK(wclass, 2'h3, "data word class")
    wr(3'h4, 8'h08);
    xfer(3'b100, 8'hFF, r[23:16]);
    `CHK(wclass, 2'h2, "command word class")
    wr(3'h4, 8'h04);
    xfer(3'b100, 8'hFF, r[7:0] ^ 8'h80);
    `CHK(wclass, 2'h1, "mismatched address class")
    rd(3'h4, v);
    `CHK(v[2], 1'b0, "release flag after mismatch")
    rd(3'h3, v);
    `CHK(v[6], 1'b0, "match flag after mismatch")
    wr(3'h5, 8'h10);
    wr(3'h4, 8'h04);
    xfer(3'b100, 8'hFF, r[7:0] ^ 8'h01);
    rd(3'h3, v);
    `CHK(v[6], 1'b1, "masked address match")
    give_verdict();
  end

  // Every word at the slowest divider stays far below this bound
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_errors++;
    give_verdict();
  end
endmodule // testbench
